// >>> lane_ecnt_pkg.sv
package lane_ecnt_pkg;

    // Register map, byte addresses on the 12-bit configuration port
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_DEFRAMER_CTRL = 12'h475;
    localparam logic [11:0] ADDR_COUNT_CLEAR0 = 12'h480;
    localparam logic [11:0] ADDR_HOLD0 = 12'h488;
    localparam logic [11:0] ADDR_HOLD1 = 12'h489;
    localparam logic [11:0] ADDR_HOLD2 = 12'h48A;
    localparam logic [11:0] ADDR_COUNT_BASE = 12'h490;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h4A0;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h4A1;
    localparam logic [11:0] ADDR_IRQ_STATUS_HI = 12'h4A2;
    localparam logic [11:0] ADDR_IRQ_MASK_HI = 12'h4A3;

    // Field positions and reset values
    localparam int SOFT_RESET_BIT = 3;
    localparam int BIT_UNEXP_CTRL = 2;
    localparam int BIT_NOT_IN_TABLE = 1;
    localparam int BIT_BAD_DISP = 0;
    localparam int ERR_TYPES = 3;
    localparam logic [2:0] HOLD_RESET = 3'h7;
    localparam logic [2:0] ENABLE_RESET = 3'h7;
    localparam logic [7:0] COUNT_TERMINAL = 8'hFF;
    localparam logic [7:0] DEFRAMER_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // One lane's error indications for one received character
    typedef struct packed {
        logic unexpected_control_char_error;
        logic code_not_in_table_error;
        logic bad_disparity_error;
    } lane_err_t;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : lane_ecnt_pkg

// >>> lane_err_counter.sv
module lane_err_counter (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_enable,
    input wire logic i_hold,
    input wire logic i_clear,
    input wire logic i_error,
    output logic [7:0] o_count,
    output logic o_terminal
);
    import lane_ecnt_pkg::*;

    logic [7:0] count_q;
    logic [7:0] count_d;

    // Next count: clear wins, then saturate or wrap
    always_comb begin
        count_d = count_q;
        if (i_clear) begin
            count_d = 8'h00;
        end else if (i_enable && i_error) begin
            if (i_hold && count_q == COUNT_TERMINAL) begin
                count_d = count_q;
            end else begin
                count_d = count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= 8'h00;
        end else if (i_ce) begin
            count_q <= count_d;
        end
    end

    assign o_count = count_q;
    assign o_terminal = i_enable && i_error && !i_clear && count_q == COUNT_TERMINAL;
endmodule : lane_err_counter

// >>> lane_error_counter_hold_ctrl.sv
// How it works
// - With hold set, a counter stops at 0xFF until software clears it.
// - With hold clear, a counter wraps from 0xFF to zero and keeps counting.
// - Hold field bit 2 unexpected control, bit 1 not-in-table, bit 0 disparity.
// - Each hold field resets to 0x7, reads back, and is writable only while deframer soft reset is set.
// - One hold register per lane at 0x488..0x48A, bits 7..3 read zero.
// - A per-lane active-high clear field zeroes counters, releasing a held one.
module lane_error_counter_hold_ctrl #(
    parameter int LANES = 3
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire lane_ecnt_pkg::reg_req_t i_req,
    input wire lane_ecnt_pkg::lane_err_t [LANES-1:0] i_lane_err,
    input wire logic [LANES-1:0] i_char_valid,
    output logic [7:0] o_rdata,
    output logic o_deframer_soft_reset,
    output logic o_irq
);
    import lane_ecnt_pkg::*;

    // Elaboration check: the map holds three lanes
    if (LANES < 1 || LANES > 3) begin : g_bad_lanes
        $error("LANES must be 1 to 3");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    // Interrupt word width: one status bit per lane and error type
    localparam int STAT_W = LANES * ERR_TYPES;

    logic [2:0] hold_q [LANES];
    logic [2:0] hold_d [LANES];
    logic [5:0] ctrl_q [LANES];
    logic [5:0] ctrl_d [LANES];
    logic [7:0] defr_q;
    logic [7:0] defr_d;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_d;
    logic [STAT_W-1:0] mask_q;
    logic [STAT_W-1:0] mask_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_q;
    logic irq_d;
    logic [7:0] count [LANES][ERR_TYPES];
    logic [STAT_W-1:0] term_evt;

    // Status and mask spread over two byte-wide registers each, padded to 16 bits
    logic [15:0] stat_view;
    logic [15:0] mask_view;
    logic [15:0] mask_wr;
    logic [15:0] clr_pad;

    // Decode of a write strobe to one register
    function automatic logic wr_hit(input reg_req_t r, input logic [11:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    // Decode of a read strobe to one register
    function automatic logic rd_hit(input reg_req_t r, input logic [11:0] a);
        rd_hit = r.rd && (r.addr == a);
    endfunction : rd_hit

    ////////////////////////////////////////////////////////////////////////////
    // Counters per lane and error type
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [2:0] err;
        assign err = i_lane_err[l] & {3{i_char_valid[l]}};
        for (genvar t = 0; t < ERR_TYPES; t++) begin : g_type
            lane_err_counter u_cnt (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_ce(i_ce),
                .i_enable(ctrl_q[l][3+t]),
                .i_hold(hold_q[l][t]),
                .i_clear(ctrl_q[l][t]),
                .i_error(err[t]),
                .o_count(count[l][t]),
                .o_terminal(term_evt[l*ERR_TYPES+t])
            );
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane counter enables and clears
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            ctrl_d[l] = ctrl_q[l];
            // Clear bits stay set, holding the counters at zero, until written low
            if (wr_hit(i_req, ADDR_COUNT_CLEAR0 + 12'(l))) begin
                ctrl_d[l] = i_req.wdata[5:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int l = 0; l < LANES; l++) begin
                ctrl_q[l] <= {ENABLE_RESET, 3'h0};
            end
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hold fields
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            hold_d[l] = hold_q[l];
            // Locked unless the deframer is in soft reset; soft reset does not stop the counters, so a change here reaches them while counting
            if (wr_hit(i_req, ADDR_HOLD0 + 12'(l)) && defr_q[SOFT_RESET_BIT]) begin
                hold_d[l] = i_req.wdata[2:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int l = 0; l < LANES; l++) begin
                hold_q[l] <= HOLD_RESET;
            end
        end else if (i_ce) begin
            hold_q <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Deframer control register
    always_comb begin
        defr_d = defr_q;
        if (wr_hit(i_req, ADDR_DEFRAMER_CTRL)) begin
            defr_d = i_req.wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            defr_q <= DEFRAMER_RESET;
        end else if (i_ce) begin
            defr_q <= defr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status, mask and interrupt
    always_comb begin
        mask_wr = 16'(mask_q);
        clr_pad = 16'h0000;
        if (wr_hit(i_req, ADDR_IRQ_MASK)) begin
            mask_wr[7:0] = i_req.wdata;
        end
        if (wr_hit(i_req, ADDR_IRQ_MASK_HI)) begin
            mask_wr[15:8] = i_req.wdata;
        end
        // Reading a status byte clears only the bits that it showed
        if (rd_hit(i_req, ADDR_IRQ_STATUS)) begin
            clr_pad[7:0] = 8'hFF;
        end
        if (rd_hit(i_req, ADDR_IRQ_STATUS_HI)) begin
            clr_pad[15:8] = 8'hFF;
        end
        mask_d = mask_wr[STAT_W-1:0];
        // Set wins over read-clear in the same cycle
        stat_d = (stat_q & ~clr_pad[STAT_W-1:0]) | term_evt;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_q <= '0;
            stat_q <= '0;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            mask_q <= mask_d;
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe; unmapped addresses read zero
    assign stat_view = 16'(stat_q);
    assign mask_view = 16'(mask_q);

    always_comb begin
        rdata_d = 8'h00;
        if (rd_hit(i_req, ADDR_DEFRAMER_CTRL)) begin
            rdata_d = defr_q;
        end
        if (rd_hit(i_req, ADDR_IRQ_STATUS)) begin
            rdata_d = stat_view[7:0];
        end
        if (rd_hit(i_req, ADDR_IRQ_STATUS_HI)) begin
            rdata_d = stat_view[15:8];
        end
        if (rd_hit(i_req, ADDR_IRQ_MASK)) begin
            rdata_d = mask_view[7:0];
        end
        if (rd_hit(i_req, ADDR_IRQ_MASK_HI)) begin
            rdata_d = mask_view[15:8];
        end
        for (int l = 0; l < LANES; l++) begin
            if (rd_hit(i_req, ADDR_HOLD0 + 12'(l))) begin
                rdata_d = {5'h00, hold_q[l]};
            end
            if (rd_hit(i_req, ADDR_COUNT_CLEAR0 + 12'(l))) begin
                rdata_d = {2'h0, ctrl_q[l]};
            end
            for (int t = 0; t < ERR_TYPES; t++) begin
                if (rd_hit(i_req, ADDR_COUNT_BASE + 12'(l*4+t))) begin
                    rdata_d = count[l][t];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
        end else if (i_ce) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign o_rdata = rdata_q;
    assign o_deframer_soft_reset = defr_q[SOFT_RESET_BIT];
    assign o_irq = irq_q;
endmodule : lane_error_counter_hold_ctrl

// >>> lane_tx_model.sv
module lane_tx_model (
    input wire logic i_clk,
    input wire logic i_send,
    output lane_ecnt_pkg::lane_err_t [2:0] o_lane_err,
    output logic [2:0] o_char_valid
);
    import lane_ecnt_pkg::*;
    // One lane-0 character per send cycle, carrying all three error kinds
    always_ff @(posedge i_clk) begin
        o_char_valid <= {2'b00, i_send};
        o_lane_err <= i_send ? 9'h007 : 9'h000;
    end
endmodule : lane_tx_model

// >>> lane_ecnt_sva.sv
module lane_ecnt_sva #(
    parameter int LANES = 3
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire lane_ecnt_pkg::reg_req_t i_req,
    input wire lane_ecnt_pkg::lane_err_t [LANES-1:0] i_lane_err,
    input wire logic [LANES-1:0] i_char_valid,
    input wire logic [7:0] o_rdata,
    input wire logic o_deframer_soft_reset,
    input wire logic o_irq
);
    import lane_ecnt_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Read data path and deframer control bit
    idle_rdata_a: assert property (i_ce && !i_req.rd |=> o_rdata == 8'h00) else $error("rdata without read");
    unmapped_read_a: assert property (i_ce && i_req.rd && i_req.addr == 12'hFFF |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    hold_reserved_a: assert property (i_ce && i_req.rd && i_req.addr inside {[ADDR_HOLD0:ADDR_HOLD2]}
        |=> o_rdata[7:3] == 5'h00) else $error("reserved hold bits set");
    ctrl_readback_a: assert property (i_ce && i_req.rd && i_req.addr == ADDR_DEFRAMER_CTRL
        |=> o_rdata[SOFT_RESET_BIT] == $past(o_deframer_soft_reset)) else $error("soft reset readback wrong");
    soft_reset_wr_a: assert property (i_ce && i_req.wr && i_req.addr == ADDR_DEFRAMER_CTRL
        |=> o_deframer_soft_reset == $past(i_req.wdata[SOFT_RESET_BIT])) else $error("soft reset not written");
    soft_reset_keep_a: assert property (!(i_ce && i_req.wr && i_req.addr == ADDR_DEFRAMER_CTRL)
        |=> $stable(o_deframer_soft_reset)) else $error("soft reset changed alone");
    ce_freeze_a: assert property (!i_ce |=> $stable(o_rdata) && $stable(o_irq)) else $error("state moved with ce low");
    rdata_change_a: assert property ($changed(o_rdata) |-> $past(i_ce)) else $error("rdata moved while frozen");
endmodule : lane_ecnt_sva
bind lane_error_counter_hold_ctrl lane_ecnt_sva #(.LANES(LANES)) chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ce(i_ce), .i_req(i_req), .i_lane_err(i_lane_err), .i_char_valid(i_char_valid), .o_rdata(o_rdata),
    .o_deframer_soft_reset(o_deframer_soft_reset), .o_irq(o_irq));

// >>> tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lane_ecnt_pkg::*;
    logic i_clk, i_reset_n, i_ce, send, o_deframer_soft_reset, o_irq;
    reg_req_t i_req;
    lane_err_t [2:0] lane_err;
    logic [2:0] char_valid;
    logic [7:0] o_rdata;
    int miscompares, compares;
    // Reads after reset: address beside expected data
    logic [19:0] rows [5] = '{{ADDR_HOLD0, 8'h07}, {ADDR_HOLD1, 8'h07}, {ADDR_HOLD2, 8'h07}, {12'hFFF, 8'h00},
        {ADDR_DEFRAMER_CTRL, 8'h00}};
    lane_error_counter_hold_ctrl #(.LANES(3)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_req(i_req),
        .i_lane_err(lane_err), .i_char_valid(char_valid), .o_rdata(o_rdata),
        .o_deframer_soft_reset(o_deframer_soft_reset), .o_irq(o_irq));
    lane_tx_model tx_u (.i_clk(i_clk), .i_send(send), .o_lane_err(lane_err), .o_char_valid(char_valid));
    task automatic check(input logic ok);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: value mismatch", $time);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        i_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clk);
        i_req.rd <= 1'b0;
        #1 check(o_rdata === e);
    endtask : rd
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    // Clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // Watchdog
    initial begin
        #20000;
        miscompares++;
        stop_test();
    end
    // Test sequence
    initial begin
        i_reset_n = 1'b0;
        i_ce = 1'b1;
        send = 1'b0;
        i_req = '0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(rows[i][19:8], rows[i][7:0]);
        $display("reset values done");
        wr(ADDR_HOLD1, 8'h02);
        rd(ADDR_HOLD1, 8'h07);
        wr(ADDR_DEFRAMER_CTRL, 8'h08);
        #1 check(o_deframer_soft_reset === 1'b1);
        wr(ADDR_HOLD1, 8'hFA);
        rd(ADDR_HOLD1, 8'h02);
        wr(ADDR_HOLD0, 8'h06);
        wr(ADDR_DEFRAMER_CTRL, 8'h00);
        $display("hold programming done");
        @(posedge i_clk) send <= 1'b1;
        // 257 characters counted; the last one arrives while i_ce is low and is frozen out
        repeat (258) @(posedge i_clk);
        send <= 1'b0;
        i_ce <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_ce <= 1'b1;
        rd(ADDR_COUNT_BASE, 8'h01);
        rd(ADDR_COUNT_BASE + 12'h001, 8'hFF);
        rd(ADDR_COUNT_BASE + 12'h002, 8'hFF);
        check(o_irq === 1'b0);
        wr(ADDR_IRQ_MASK, 8'h07);
        repeat (2) @(posedge i_clk);
        check(o_irq === 1'b1);
        rd(ADDR_IRQ_STATUS, 8'h07);
        repeat (2) @(posedge i_clk);
        check(o_irq === 1'b0);
        wr(ADDR_COUNT_CLEAR0, 8'h3F);
        wr(ADDR_COUNT_CLEAR0, 8'h38);
        rd(ADDR_COUNT_BASE + 12'h001, 8'h00);
        // A released counter counts again from zero
        @(posedge i_clk) send <= 1'b1;
        @(posedge i_clk) send <= 1'b0;
        rd(ADDR_COUNT_BASE + 12'h001, 8'h01);
        wr(ADDR_IRQ_MASK_HI, 8'hFF);
        rd(ADDR_IRQ_MASK_HI, 8'h01);
        $display("counting and clear done");
        // Reset in mid-run with the deframer in soft reset and lane 0 hold changed
        wr(ADDR_DEFRAMER_CTRL, 8'h08);
        @(posedge i_clk) i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(ADDR_HOLD0, 8'h07);
        check(o_deframer_soft_reset === 1'b0);
        rd(ADDR_IRQ_MASK_HI, 8'h00);
        $display("mid-run reset done");
        stop_test();
    end
endmodule : tb_top
